//--- inc/cpo_pkg.sv
// Purpose : constants for the compare and pwm output channel
// Assumes : one 25 MHz clock, registers on an 8-bit AXI4-Lite window
// Notes   : every register is one aligned word, data in bits 7:0
package cpo_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00; // channel_control_reg
	localparam logic [7:0] OFS_CMP_LOW  = 8'h04; // compare_value_low
	localparam logic [7:0] OFS_CMP_HIGH = 8'h08; // compare_value_high
	localparam logic [7:0] OFS_TSEL     = 8'h0c; // pwm_timer_select_reg
	localparam logic [7:0] OFS_LIMIT0   = 8'h10; // period_limit_reg, one per timer
	localparam logic [7:0] OFS_TCTL0    = 8'h20; // period_timer_control
	localparam logic [7:0] OFS_COUNT0   = 8'h30; // period_timer_8
	localparam logic [7:0] OFS_STEP     = 8'h04;
	localparam int         NUM_TIMERS   = 3;
	localparam logic [7:0] RST_BYTE     = 8'h00;

	// ------------------------------------------------------------
	// fields
	// ------------------------------------------------------------
	localparam int CTRL_EN_BIT  = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_FMT_BIT = 4;
	localparam int TCTL_FLAG_BIT = 7;
	localparam int TCTL_ON_BIT   = 2;
	localparam logic [3:0] MODE_OFF        = 4'h0;
	localparam logic [3:0] MODE_TOGGLE_CLR = 4'h1;
	localparam logic [3:0] MODE_TOGGLE     = 4'h2;
	localparam logic [3:0] MODE_SET        = 4'h8;
	localparam logic [3:0] MODE_CLEAR      = 4'h9;
	localparam logic [3:0] MODE_SWINT      = 4'ha;
	localparam logic [3:0] MODE_PULSE_CLR  = 4'hb;
	localparam logic [1:0] MODE_PWM_TOP    = 2'h3;
	localparam logic [1:0] TSEL_RESERVED   = 2'h3;
	localparam logic [1:0] QUARTER_LAST    = 2'h3;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;
	// last prescaler count for 1:1, 1:4, 1:16, 1:64
	localparam logic [5:0] PS_LAST [4] = '{6'h00, 6'h03, 6'h0f, 6'h3f};

	typedef enum {
		ACT_NONE,
		ACT_TOGGLE,
		ACT_SET,
		ACT_CLEAR,
		ACT_PULSE,
		ACT_PWM
	} cpo_action_type;
endpackage

//--- logic/cpo_channel.sv
// Purpose : one compare / pwm output channel with three 8-bit period timers
// Assumes : free_running_timer_16 comes from logic on aclk
// Notes   : capture modes are decoded but leave the output idle
`timescale 1ns/100ps

// Overview of operation
// RL1: software-interrupt compare mode signals the match only, pin never driven.
// RL2: compare runs on the system clock; stopped clock means no matching.
// RL3: pulse compare modes hold output high while timer equals compare value.
// RL4: toggle compare modes invert the output on each match.
// RL5: clear mode drives output low on match, set mode drives high.
// RL6: output is also offered internally and to the pin remap unit.
// RL7: pwm mode makes a waveform with up to ten bits of duty.
// RL8: writing zero to the control register releases the pin.
// RL9: a shared select register picks one of three timers per channel.
// RL10: software must clock the chosen period timer from quarter system clock.
// RL11: pwm period is (limit+1) times four clocks times the prescale.
// RL12: after timer equals limit: clear timer, set pin unless zero, latch duty.
// RL13: right aligned duty takes high bits 1:0 and the low byte.
// RL14: left aligned duty takes the high byte and low bits 7:6.
// RL15: duty registers are double buffered, new duty taken at period end.
// RL16: time base is timer plus two low bits from clock phase or prescaler.
// RL17: time base equal to latched duty drives the pin low.
// RL18: resolution is log2 of four times limit plus one, ten at 255.
// RL19: duty beyond the period leaves the pin level unchanged.
// RL20: no postscaler acts on the pwm period.
// RL21: software sets up pin, timer, limit, mode, duty, then starts timer.
// RL22: mode top bits both one select pwm; all-zero mode resets channel.
// RL23: timer code 00, 01, 10 pick timers one to three; 11 reserved.
// RL24: control holds enable bit 7, output bit 5, alignment 4, mode 3:0.
module cpo_channel (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [15:0] free_running_timer_16,
	output logic             channel_out,
	output logic             pin_out,
	output logic             pin_oe,
	output logic             match_event,
	output logic             clear_timer_request,
	output logic [2:0]       period_timer_flag
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic        ctrl_en;
	logic        duty_alignment_select;
	logic [3:0]  mode;
	logic [7:0]  compare_value_low;
	logic [7:0]  compare_value_high;
	logic [7:0]  pwm_timer_select_reg;
	logic        out_level;
	logic        match_q;
	logic [9:0]  duty_latch;
	logic [1:0]  quarter;
	logic [7:0]  period_limit_reg [3];
	logic [7:0]  period_timer_8 [3];
	logic [1:0]  timer_prescale_field [3];
	logic [2:0]  timer_on;
	logic [2:0]  wrap;
	logic [9:0]  time_base [3];

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr_q;
	logic [7:0]  w_data_q;
	logic        w_lane0;
	logic        wr_go;
	logic        wr_en;
	logic [7:0]  rd_value;
	logic        rd_hit;

	function automatic logic addr_hit(input logic [7:0] a);
		logic hit;
		hit = (a == cpo_pkg::OFS_CTRL) || (a == cpo_pkg::OFS_CMP_LOW)
			|| (a == cpo_pkg::OFS_CMP_HIGH) || (a == cpo_pkg::OFS_TSEL);
		for (int i = 0; i < cpo_pkg::NUM_TIMERS; i++) begin
			if (a == cpo_pkg::OFS_LIMIT0 + cpo_pkg::OFS_STEP * 8'(i)
				|| a == cpo_pkg::OFS_TCTL0 + cpo_pkg::OFS_STEP * 8'(i)
				|| a == cpo_pkg::OFS_COUNT0 + cpo_pkg::OFS_STEP * 8'(i)) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// address and data are taken independently, answered when both are in
	assign awready = !aw_held && !bvalid;
	assign wready  = !w_held && !bvalid;
	assign arready = !rvalid;
	assign wr_go   = aw_held && w_held;
	assign wr_en   = wr_go && w_lane0 && addr_hit(aw_addr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= cpo_pkg::RST_BYTE;
			w_data_q  <= cpo_pkg::RST_BYTE;
			w_lane0   <= 1'b0;
		end else if (wr_go) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_held   <= 1'b1;
				w_data_q <= wdata[7:0];
				w_lane0  <= wstrb[0];
			end
		end
	end

	// write answer, unmapped addresses get slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= cpo_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= addr_hit(aw_addr_q) ? cpo_pkg::RESP_OKAY : cpo_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// read mux; bit 6 of control reads zero
	always_comb begin
		rd_value = cpo_pkg::RST_BYTE;
		rd_hit   = addr_hit(araddr);
		if (araddr == cpo_pkg::OFS_CTRL) begin
			rd_value = {ctrl_en, 1'b0, out_level, duty_alignment_select, mode}; // RL24
		end else if (araddr == cpo_pkg::OFS_CMP_LOW) begin
			rd_value = compare_value_low;
		end else if (araddr == cpo_pkg::OFS_CMP_HIGH) begin
			rd_value = compare_value_high;
		end else if (araddr == cpo_pkg::OFS_TSEL) begin
			rd_value = pwm_timer_select_reg;
		end else begin
			for (int i = 0; i < cpo_pkg::NUM_TIMERS; i++) begin
				if (araddr == cpo_pkg::OFS_LIMIT0 + cpo_pkg::OFS_STEP * 8'(i)) begin
					rd_value = period_limit_reg[i];
				end else if (araddr == cpo_pkg::OFS_TCTL0 + cpo_pkg::OFS_STEP * 8'(i)) begin
					rd_value = {period_timer_flag[i], 4'h0, timer_on[i],
						timer_prescale_field[i]};
				end else if (araddr == cpo_pkg::OFS_COUNT0 + cpo_pkg::OFS_STEP * 8'(i)) begin
					rd_value = period_timer_8[i];
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= cpo_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= {24'h00_0000, rd_value};
			rresp  <= rd_hit ? cpo_pkg::RESP_OKAY : cpo_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// channel registers
	// ------------------------------------------------------------
	logic ctrl_wr;
	assign ctrl_wr = wr_en && aw_addr_q == cpo_pkg::OFS_CTRL;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_en               <= 1'b0;
			duty_alignment_select <= 1'b0;
			mode                  <= cpo_pkg::MODE_OFF;
			compare_value_low     <= cpo_pkg::RST_BYTE;
			compare_value_high    <= cpo_pkg::RST_BYTE;
			pwm_timer_select_reg  <= cpo_pkg::RST_BYTE;
		end else if (wr_en) begin
			if (aw_addr_q == cpo_pkg::OFS_CTRL) begin
				ctrl_en               <= w_data_q[cpo_pkg::CTRL_EN_BIT];
				duty_alignment_select <= w_data_q[cpo_pkg::CTRL_FMT_BIT];
				mode                  <= w_data_q[3:0];
			end else if (aw_addr_q == cpo_pkg::OFS_CMP_LOW) begin
				compare_value_low <= w_data_q; // RL15
			end else if (aw_addr_q == cpo_pkg::OFS_CMP_HIGH) begin
				compare_value_high <= w_data_q; // RL15
			end else if (aw_addr_q == cpo_pkg::OFS_TSEL) begin
				pwm_timer_select_reg <= w_data_q; // RL9
			end
		end
	end

	// ------------------------------------------------------------
	// period timers, clocked from the quarter-rate instruction phase
	// ------------------------------------------------------------
	// quarter-rate phase; software must pick this source for pwm use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			quarter <= 2'h0;
		end else begin
			quarter <= quarter + 2'h1; // RL10
		end
	end

	for (genvar t = 0; t < cpo_pkg::NUM_TIMERS; t++) begin : g_timer
		logic [7:0] ofs_limit;
		logic [7:0] ofs_tctl;
		logic [7:0] ofs_count;
		logic [5:0] pre;
		logic [1:0] low2;
		logic       inc;

		assign ofs_limit = cpo_pkg::OFS_LIMIT0 + cpo_pkg::OFS_STEP * 8'(t);
		assign ofs_tctl  = cpo_pkg::OFS_TCTL0 + cpo_pkg::OFS_STEP * 8'(t);
		assign ofs_count = cpo_pkg::OFS_COUNT0 + cpo_pkg::OFS_STEP * 8'(t);
		assign inc = timer_on[t] && quarter == cpo_pkg::QUARTER_LAST
			&& pre == cpo_pkg::PS_LAST[timer_prescale_field[t]]; // RL11
		// no postscaler here: the period is limit and prescale alone
		assign wrap[t] = inc && period_timer_8[t] == period_limit_reg[t]; // RL20

		// two extra low bits: clock phase at 1:1, else prescaler bits
		always_comb begin
			case (timer_prescale_field[t])
				2'h0:    low2 = quarter; // RL16
				2'h1:    low2 = pre[1:0];
				2'h2:    low2 = pre[3:2];
				default: low2 = pre[5:4];
			endcase
		end
		assign time_base[t] = {period_timer_8[t], low2}; // RL16

		// limit, prescale and enable
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				period_limit_reg[t]     <= cpo_pkg::RST_BYTE;
				timer_prescale_field[t] <= 2'h0;
				timer_on[t]             <= 1'b0;
			end else if (wr_en && aw_addr_q == ofs_limit) begin
				period_limit_reg[t] <= w_data_q;
			end else if (wr_en && aw_addr_q == ofs_tctl) begin
				timer_prescale_field[t] <= w_data_q[1:0];
				timer_on[t]             <= w_data_q[cpo_pkg::TCTL_ON_BIT];
			end
		end

		// count and prescaler; a write to the count restarts the prescaler
		always_ff @(posedge aclk) begin
			if (!aresetn || !timer_on[t]) begin
				pre <= 6'h00;
				if (!aresetn) begin
					period_timer_8[t] <= cpo_pkg::RST_BYTE;
				end
			end else if (wr_en && aw_addr_q == ofs_count) begin
				pre               <= 6'h00;
				period_timer_8[t] <= w_data_q;
			end else if (quarter == cpo_pkg::QUARTER_LAST) begin
				if (inc) begin
					pre <= 6'h00;
					if (wrap[t]) begin
						period_timer_8[t] <= cpo_pkg::RST_BYTE; // RL12
					end else begin
						period_timer_8[t] <= period_timer_8[t] + 8'h01;
					end
				end else begin
					pre <= pre + 6'h01;
				end
			end
		end

		// period flag: write one clears, a wrap in the same cycle wins
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				period_timer_flag[t] <= 1'b0;
			end else if (wrap[t]) begin
				period_timer_flag[t] <= 1'b1;
			end else if (wr_en && aw_addr_q == ofs_tctl
				&& w_data_q[cpo_pkg::TCTL_FLAG_BIT]) begin
				period_timer_flag[t] <= 1'b0;
			end
		end

		a_timer_wrap_clear: assert property (@(posedge aclk) disable iff (!aresetn)
			wrap[t] && !wr_en |=> period_timer_8[t] == 8'h00 && period_timer_flag[t]) // RL12
			else $error("period timer did not clear and flag on wrap");
	end

	// ------------------------------------------------------------
	// mode decode and timer selection
	// ------------------------------------------------------------
	cpo_pkg::cpo_action_type act;
	logic       compare_match;
	logic       match_rise;
	logic [1:0] tsel;
	logic       sel_wrap;
	logic [9:0] sel_tb;
	logic [9:0] duty_value;

	// compare needs aclk running; with the clock stopped nothing matches
	assign compare_match = free_running_timer_16 == {compare_value_high, compare_value_low}; // RL2
	assign match_rise    = compare_match && !match_q;
	assign tsel          = pwm_timer_select_reg[1:0];

	always_comb begin
		act = cpo_pkg::ACT_NONE;
		if (!ctrl_en) begin
			act = cpo_pkg::ACT_NONE;
		end else if (mode[3:2] == cpo_pkg::MODE_PWM_TOP) begin
			act = cpo_pkg::ACT_PWM; // RL22
		end else begin
			case (mode)
				cpo_pkg::MODE_TOGGLE_CLR: act = cpo_pkg::ACT_TOGGLE;
				cpo_pkg::MODE_TOGGLE:     act = cpo_pkg::ACT_TOGGLE;
				cpo_pkg::MODE_SET:        act = cpo_pkg::ACT_SET;
				cpo_pkg::MODE_CLEAR:      act = cpo_pkg::ACT_CLEAR;
				cpo_pkg::MODE_SWINT:      act = cpo_pkg::ACT_PULSE;
				cpo_pkg::MODE_PULSE_CLR:  act = cpo_pkg::ACT_PULSE;
				default:                  act = cpo_pkg::ACT_NONE;
			endcase
		end
	end

	// code 11 is reserved and gives no time base at all
	always_comb begin
		case (tsel)
			2'h0: begin
				sel_wrap = wrap[0]; // RL23
				sel_tb   = time_base[0];
			end
			2'h1: begin
				sel_wrap = wrap[1];
				sel_tb   = time_base[1];
			end
			2'h2: begin
				sel_wrap = wrap[2];
				sel_tb   = time_base[2];
			end
			default: begin
				sel_wrap = 1'b0;
				sel_tb   = 10'h000;
			end
		endcase
	end

	// duty assembly from the two compare bytes
	always_comb begin
		if (duty_alignment_select) begin
			duty_value = {compare_value_high, compare_value_low[7:6]}; // RL14
		end else begin
			duty_value = {compare_value_high[1:0], compare_value_low}; // RL13
		end
	end

	// ------------------------------------------------------------
	// output level
	// ------------------------------------------------------------
	// edge of the match so a stalled timer does not retrigger the action
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_q <= 1'b0;
		end else begin
			match_q <= compare_match;
		end
	end

	// duty buffer: loaded only at the period end
	always_ff @(posedge aclk) begin
		if (!aresetn || mode == cpo_pkg::MODE_OFF) begin
			duty_latch <= 10'h000;
		end else if (act == cpo_pkg::ACT_PWM && sel_wrap) begin
			duty_latch <= duty_value; // RL15
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_level <= 1'b0;
		end else begin
			case (act)
				cpo_pkg::ACT_TOGGLE: if (match_rise) begin
					out_level <= !out_level; // RL4
				end
				cpo_pkg::ACT_SET: if (match_rise) begin
					out_level <= 1'b1; // RL5
				end
				cpo_pkg::ACT_CLEAR: if (match_rise) begin
					out_level <= 1'b0; // RL5
				end
				cpo_pkg::ACT_PULSE: out_level <= compare_match; // RL3
				cpo_pkg::ACT_PWM: begin
					// a duty past the period never matches, so the level holds;
					// the reserved timer code has no time base and parks the output low
					if (tsel == cpo_pkg::TSEL_RESERVED) begin
						out_level <= 1'b0; // RL23
					end else if (sel_wrap) begin
						out_level <= duty_value != 10'h000; // RL12 RL7 RL18
					end else if (sel_tb == duty_latch) begin
						out_level <= 1'b0; // RL17 RL19
					end
				end
				default: out_level <= 1'b0; // RL22
			endcase
		end
	end

	// match pulse and timer-clear request for the free-running timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_event         <= 1'b0;
			clear_timer_request <= 1'b0;
		end else begin
			match_event <= match_rise && act != cpo_pkg::ACT_NONE
				&& act != cpo_pkg::ACT_PWM; // RL1
			clear_timer_request <= match_rise && ctrl_en
				&& (mode == cpo_pkg::MODE_TOGGLE_CLR || mode == cpo_pkg::MODE_PULSE_CLR);
		end
	end

	// internal copy feeds converter, timers, window and logic cells
	assign channel_out = out_level; // RL6
	assign pin_out     = out_level;
	assign pin_oe      = act != cpo_pkg::ACT_NONE && mode != cpo_pkg::MODE_SWINT; // RL1 RL8

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_swint_no_drive: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
		mode == cpo_pkg::MODE_SWINT |-> !pin_oe)
		else $error("pin driven in software interrupt mode");
	a_pulse_on_match: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
		act == cpo_pkg::ACT_PULSE && !ctrl_wr |=> channel_out == $past(compare_match))
		else $error("pulse output does not follow the match");
	a_toggle_inverts: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
		act == cpo_pkg::ACT_TOGGLE && match_rise && !ctrl_wr |=> channel_out != $past(channel_out))
		else $error("toggle mode did not invert on match");
	a_clear_set_match: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
		match_rise && !ctrl_wr && (act == cpo_pkg::ACT_SET || act == cpo_pkg::ACT_CLEAR)
		|=> channel_out == ($past(mode) == cpo_pkg::MODE_SET))
		else $error("set or clear on match went wrong");
	a_off_release: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
		ctrl_wr && w_data_q == 8'h00 |=> !pin_oe ##1 !channel_out)
		else $error("cleared control did not release the pin");
	a_period_latch: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
		act == cpo_pkg::ACT_PWM && sel_wrap && !ctrl_wr
		|=> duty_latch == $past(duty_value) && channel_out == ($past(duty_value) != 10'h000))
		else $error("duty not latched or pin not set at period end");
	a_duty_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
		act == cpo_pkg::ACT_PWM && !sel_wrap && sel_tb == duty_latch && !ctrl_wr
		|=> !channel_out)
		else $error("pin not cleared at duty match");
	a_duty_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
		act == cpo_pkg::ACT_PWM && !sel_wrap && !ctrl_wr |=> $stable(duty_latch))
		else $error("duty latch changed inside a period");
endmodule

//--- test/cpo_load_model.sv
// Purpose : load on the channel output, pin plus internal consumer
// Assumes : the pin has a pull-down while nobody drives it
// Notes   : lengths count aclk cycles
`timescale 1ns/100ps
module cpo_load_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        channel_out,
	input  wire logic        pin_out,
	input  wire logic        pin_oe,
	output logic             pin_level,
	output logic [15:0]      high_len,
	output logic [15:0]      period_len,
	output logic [15:0]      rises
);
	logic        last;
	logic [15:0] hcnt;
	logic [15:0] pcnt;

	// a released pin falls to the pull-down, never keeps the last level
	assign pin_level = pin_oe ? pin_out : 1'b0;

	// internal consumer times the waveform from edge to edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last <= 1'b0;
			hcnt <= 16'h0000;
			pcnt <= 16'h0000;
			high_len <= 16'h0000;
			period_len <= 16'h0000;
			rises <= 16'h0000;
		end else begin
			last <= channel_out;
			hcnt <= channel_out ? hcnt + 16'h0001 : 16'h0000;
			pcnt <= pcnt + 16'h0001;
			if (last && !channel_out)
				high_len <= hcnt;
			if (!last && channel_out) begin
				period_len <= pcnt;
				pcnt <= 16'h0001;
				rises <= rises + 16'h0001;
			end
		end
	end
endmodule

//--- test/tb_compare_and_pwm_output.sv
// Purpose : register driven test of the compare and pwm channel
// Assumes : AXI4-Lite master, free timer wraps at 0x3f to keep runs short
// Notes   : pwm lengths are read from the load model
`timescale 1ns/100ps
module tb_compare_and_pwm_output;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [15:0] ftimer = 16'h0000;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        channel_out, pin_out, pin_oe, match_event, clear_timer_request;
	logic        pin_level, s;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, d;
	logic [2:0]  period_timer_flag;
	logic [15:0] high_len, period_len, rises;
	logic [3:0]  m;
	int          failures = 0;
	int          total_checks = 0;

	cpo_channel i_cpo_channel (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.free_running_timer_16(ftimer), .channel_out(channel_out), .pin_out(pin_out),
		.pin_oe(pin_oe), .match_event(match_event),
		.clear_timer_request(clear_timer_request), .period_timer_flag(period_timer_flag));
	cpo_load_model i_cpo_load_model (.aclk(aclk), .aresetn(aresetn),
		.channel_out(channel_out), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_level(pin_level), .high_len(high_len), .period_len(period_len),
		.rises(rises));

	// ------------------------------------------------------------
	// clock, free timer and bus tasks
	// ------------------------------------------------------------
	always #20 aclk = ~aclk;
	// short wrap gives a match every 64 cycles
	always @(posedge aclk) ftimer <= (ftimer == 16'h003f) ? 16'h0000 : ftimer + 16'h0001;

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task chk_bit(input string n, input logic e, input logic g);
		chk(n, {15'h0000, e}, {15'h0000, g});
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		bit got;
		got = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50 && !got; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				got = 1;
				bready <= 1'b0;
				resp = bresp;
			end
		end
		chk_bit("write answer", 1'b1, got);
	endtask
	task rd(input logic [7:0] a);
		bit got;
		got = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50 && !got; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				got = 1;
				rready <= 1'b0;
				d = rdata;
				resp = rresp;
			end
		end
		chk_bit("read answer", 1'b1, got);
	endtask
	// look just after the edge that raised the match pulse
	task wait_match;
		for (int i = 0; i < 100; i++) begin
			@(posedge aclk);
			#1;
			if (match_event === 1'b1) break;
		end
		chk_bit("match event", 1'b1, match_event);
	endtask
	// no new rising edge over the second 48-cycle window means the level is held
	task stuck(input logic lvl);
		logic [15:0] r;
		repeat (48) @(posedge aclk);
		r = rises;
		repeat (48) @(posedge aclk);
		chk("rises", r, rises);
		chk_bit("level", lvl, channel_out);
	endtask
	task note(input string n);
		$display("test %s done", n);
	endtask
	task close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		#400000;
		failures++;
		close_out;
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(cpo_pkg::OFS_CTRL);
		chk("ctrl reset", 16'h0000, d[15:0]);
		rd(8'h40);
		chk("unmapped", 16'h0002, {14'h0000, resp});
		wr(8'h40, 8'h01);
		chk("unmapped write", 16'h0002, {14'h0000, resp});
		wr(cpo_pkg::OFS_LIMIT0, 8'h03);
		rd(cpo_pkg::OFS_LIMIT0);
		chk("limit", 16'h0003, d[15:0]);
		note("registers");
		wr(cpo_pkg::OFS_CMP_LOW, 8'h20);
		wr(cpo_pkg::OFS_CMP_HIGH, 8'h00);
		wr(cpo_pkg::OFS_CTRL, 8'h88);
		wait_match;
		chk_bit("set out", 1'b1, channel_out);
		chk_bit("pin level", 1'b1, pin_level);
		wr(cpo_pkg::OFS_CTRL, 8'h89);
		wait_match;
		chk_bit("clear out", 1'b0, channel_out);
		wr(cpo_pkg::OFS_CTRL, 8'h82);
		wait_match;
		s = channel_out;
		wait_match;
		chk_bit("toggle", ~s, channel_out);
		for (m = 4'ha; m <= 4'hb; m++) begin
			wr(cpo_pkg::OFS_CTRL, {4'h8, m});
			wait_match;
			chk_bit("pulse", 1'b1, channel_out);
			chk_bit("pulse drive", m == 4'hb, pin_level);
			chk_bit("timer clear", m == 4'hb, clear_timer_request);
			@(posedge aclk);
			#1;
			chk_bit("pulse end", 1'b0, channel_out);
		end
		wr(cpo_pkg::OFS_CTRL, 8'h00);
		chk_bit("release", 1'b0, pin_oe);
		note("compare");
		// setup order and quarter clock source kept by this stimulus
		wr(cpo_pkg::OFS_TSEL, 8'h00);
		wr(cpo_pkg::OFS_CTRL, 8'h8c);
		wr(cpo_pkg::OFS_CMP_LOW, 8'h06);
		wr(cpo_pkg::OFS_TCTL0, 8'h04);
		repeat (64) @(posedge aclk);
		chk_bit("wrap flag", 1'b1, period_timer_flag[0]);
		// the registered output falls one clock after the time base reaches the duty
		chk("high", 16'd7, high_len);
		chk("period", 16'd16, period_len);
		wr(cpo_pkg::OFS_CMP_HIGH, 8'h01);
		stuck(1'b1);
		wr(cpo_pkg::OFS_CMP_HIGH, 8'h00);
		wr(cpo_pkg::OFS_CMP_LOW, 8'h00);
		stuck(1'b0);
		wr(cpo_pkg::OFS_CMP_LOW, 8'h06);
		wr(cpo_pkg::OFS_TCTL0, 8'h05);
		repeat (200) @(posedge aclk);
		chk("high 1:4", 16'd25, high_len);
		chk("period 1:4", 16'd64, period_len);
		note("pwm right");
		wr(cpo_pkg::OFS_LIMIT0 + cpo_pkg::OFS_STEP, 8'h07);
		wr(cpo_pkg::OFS_TSEL, 8'h01);
		wr(cpo_pkg::OFS_CTRL, 8'h9c);
		wr(cpo_pkg::OFS_CMP_HIGH, 8'h02);
		wr(cpo_pkg::OFS_CMP_LOW, 8'h80);
		wr(cpo_pkg::OFS_TCTL0 + cpo_pkg::OFS_STEP, 8'h04);
		repeat (100) @(posedge aclk);
		chk("high left", 16'd11, high_len);
		chk("period t1", 16'd32, period_len);
		wr(cpo_pkg::OFS_TSEL, 8'h03);
		stuck(1'b0);
		note("pwm left");
		close_out;
	end
endmodule
